// file: laser_ranger_control_interface.sv
// Serial slave, register bank, measurement sequencer and trigger pin of the ranger
//
// How it works
// - After reset, self-test and defaults, then accept measurements only after 22 ms.
// - Answer as serial slave at address 0x62 (bytes 0xC4 write, 0xC5 read).
// - Ignore general call; ten-bit addressing is not supported.
// - Slave works with bus clocks up to 400 kHz.
// - First data byte sets pointer; its top bit enables pointer auto-increment.
// - Any non-zero write to offset 0x00 starts a measurement.
// - Status bit 0 is high while measuring, low on completion.
// - Distance is unsigned 16-bit centimetres, high byte 0x0f, low 0x10.
// - Calibrate receiver and zero delay before measuring, repeated every few measurements.
// - Accumulate acquisitions until peak saturates or count in 0x02 reached.
// - Valid only if peak beats noise-derived threshold; else report 1 cm.
// - Clear the correlation record at the start of each measurement.
// - With bit 3 of 0x04 clear, stop early on predicted saturation.
// - Non-zero 0x1c replaces the adaptive test with a fixed threshold.
// - Serial unlock, new address at 0x1a, 0x08 to 0x1e drops default.
// - Alternate address is lost on power cycle; default answers again.
// - Bit 1 of 0x65 switches receiver off; it settles before measuring.
// - Trigger pin idles released; host pulling it low starts a measurement.
// - After a pin measurement, drive pin high 10 us per centimetre.
// - Pin held low repeats measurements, giving a continuous pulse train.
`timescale 1ns/1ps
`default_nettype none
`include "ranger_params.svh"

module laser_ranger_control_interface #(
  parameter int unsigned  STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter logic [15:0] SERIAL_NUMBER  = 16'h1234  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  // Serial bus pins
  input  wire logic                    i_scl_in,
  input  wire logic                    i_sda_in,
  output logic                         o_sda_out,
  output logic                         o_sda_oe_n,
  // Trigger pin
  input  wire logic                    i_pin_in,
  output logic                         o_pin_out,
  output logic                         o_pin_oe_n,
  // Analog front end
  input  wire ranger_pkg::afe_result_t i_afe,
  output ranger_pkg::afe_ctrl_t        o_afe
);
  import ranger_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam core_state_t RESET_STATE = '{
    scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
    pin_m: 1'b1, pin_s: 1'b1, bst: ST_IDLE, mst: M_BOOT,
    max_count: `RST_MAX_COUNT, acq_setup: `RST_ACQ_SETUP,
    level_override: `RST_LEVEL_OVERRIDE, addr_ctrl: `RST_ADDR_CTRL,
    rx_shutdown: `RST_RX_SHUTDOWN, default: '0};

  core_state_t cur;
  core_state_t next_cur;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        addr_hit;
  logic        peak_valid;
  logic        busy;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Register read decode; unmapped offsets read as zero
  function automatic logic [7:0] read_reg(input logic [6:0] a, input core_state_t s,
                                          input logic bsy);
    case (a)
      `REG_STATUS:         read_reg = {7'h00, bsy};
      `REG_MAX_COUNT:      read_reg = s.max_count;
      `REG_ACQ_SETUP:      read_reg = s.acq_setup;
      `REG_DIST_HIGH:      read_reg = s.distance[15:8];
      `REG_DIST_LOW:       read_reg = s.distance[7:0];
      `REG_SERIAL_UPPER:   read_reg = SERIAL_NUMBER[15:8];
      `REG_SERIAL_LOWER:   read_reg = SERIAL_NUMBER[7:0];
      `REG_ALT_ADDR:       read_reg = s.alt_addr;
      `REG_LEVEL_OVERRIDE: read_reg = s.level_override;
      `REG_ADDR_CTRL:      read_reg = s.addr_ctrl;
      `REG_RX_SHUTDOWN:    read_reg = s.rx_shutdown;
      default:             read_reg = 8'h00;
    endcase
  endfunction

  // Validity test: fixed threshold when overridden, else 1.5 x noise floor
  function automatic logic peak_beats(input logic [15:0] pk, input logic [15:0] nf,
                                      input logic [7:0] ovr);
    logic [16:0] adaptive;
    adaptive = {1'b0, nf} + {2'b00, nf[15:1]};
    if (ovr != 8'h00) begin
      peak_beats = (pk > {8'h00, ovr});
    end else begin
      peak_beats = ({1'b0, pk} > adaptive);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin conditions seen through the synchronisers
  // ----------------------------------------------------------------------
  // Edges sampled at 100 MHz keep up with 400 kHz bus clocks
  assign scl_rise  = cur.scl_s & ~cur.scl_d;
  assign scl_fall  = ~cur.scl_s & cur.scl_d;
  assign bus_start = cur.scl_s & cur.scl_d & ~cur.sda_s & cur.sda_d;
  assign bus_stop  = cur.scl_s & cur.scl_d & cur.sda_s & ~cur.sda_d;
  assign busy      = (cur.mst != M_IDLE) && (cur.mst != M_BOOT);
  assign peak_valid = peak_beats(i_afe.peak, i_afe.noise_floor, cur.level_override);

  // Address match: default unless disabled, plus a non-zero alternate;
  // address zero (general call) and 11110xx never match
  assign addr_hit =
    ((cur.shift[7:1] == `DEFAULT_BUS_ADDR) && !cur.addr_ctrl[`DEFAULT_ADDR_OFF_BIT]) ||
    ((cur.alt_addr[6:0] != 7'h00) && (cur.alt_addr[6:3] != 4'hf) &&
     (cur.shift[7:1] == cur.alt_addr[6:0]));

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic       wr_en;
    logic       load_rd;
    logic       meas_req;
    logic       pin_req;
    logic [7:0] rd;
    logic [8:0] cnt_inc;
    wr_en    = 1'b0;
    load_rd  = 1'b0;
    meas_req = 1'b0;
    pin_req  = 1'b0;
    rd       = 8'h00;
    cnt_inc  = cur.acq_cnt + 9'h001;
    next_cur = cur;
    next_cur.cal_start = 1'b0;
    next_cur.clear_rec = 1'b0;
    next_cur.acq_start = 1'b0;

    // Two-flop synchronisers, then a delayed copy for edges
    next_cur.scl_m = i_scl_in;
    next_cur.scl_s = cur.scl_m;
    next_cur.scl_d = cur.scl_s;
    next_cur.sda_m = i_sda_in;
    next_cur.sda_s = cur.sda_m;
    next_cur.sda_d = cur.sda_s;
    next_cur.pin_m = i_pin_in;
    next_cur.pin_s = cur.pin_m;

    // Serial slave bit engine
    if (bus_start) begin
      next_cur.bst     = ST_ADDR;
      next_cur.bcnt    = 4'h0;
      next_cur.first   = 1'b1;
      next_cur.sda_low = 1'b0;
    end else if (bus_stop) begin
      next_cur.bst     = ST_IDLE;
      next_cur.sda_low = 1'b0;
    end else if (scl_rise) begin
      case (cur.bst)
        ST_ADDR, ST_WDATA: begin
          next_cur.shift = {cur.shift[6:0], cur.sda_s};
          next_cur.bcnt  = cur.bcnt + 4'h1;
        end
        ST_ACK_R: next_cur.nack = cur.sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (cur.bst)
        ST_ADDR: begin
          if (cur.bcnt == 4'h8) begin
            if (addr_hit) begin
              next_cur.bst     = ST_ACK_ADDR;
              next_cur.sda_low = 1'b1;
              next_cur.rw      = cur.shift[0];
            end else begin
              next_cur.bst = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (cur.rw) begin
            load_rd = 1'b1;
          end else begin
            next_cur.bst     = ST_WDATA;
            next_cur.bcnt    = 4'h0;
            next_cur.sda_low = 1'b0;
          end
        end
        ST_WDATA: begin
          if (cur.bcnt == 4'h8) begin
            next_cur.bst     = ST_ACK_W;
            next_cur.sda_low = 1'b1;
            if (cur.first) begin
              next_cur.ptr   = cur.shift;
              next_cur.first = 1'b0;
            end else begin
              wr_en = 1'b1;
              if (cur.ptr[`AUTO_INC_BIT]) begin
                next_cur.ptr = {1'b1, cur.ptr[6:0] + 7'h01};
              end
            end
          end
        end
        ST_ACK_W: begin
          next_cur.bst     = ST_WDATA;
          next_cur.bcnt    = 4'h0;
          next_cur.sda_low = 1'b0;
        end
        ST_RDATA: begin
          if (cur.bcnt == 4'h8) begin
            next_cur.bst     = ST_ACK_R;
            next_cur.sda_low = 1'b0;
          end else begin
            next_cur.sda_low = ~cur.shift[7];
            next_cur.shift   = {cur.shift[6:0], 1'b0};
            next_cur.bcnt    = cur.bcnt + 4'h1;
          end
        end
        ST_ACK_R: begin
          if (cur.nack) begin
            next_cur.bst     = ST_IDLE;
            next_cur.sda_low = 1'b0;
          end else begin
            load_rd = 1'b1;
          end
        end
        default: next_cur.bst = ST_IDLE;
      endcase
    end

    // Load a read byte and put its top bit on the line
    if (load_rd) begin
      rd                = read_reg(cur.ptr[6:0], cur, busy);
      next_cur.bst      = ST_RDATA;
      next_cur.bcnt     = 4'h1;
      next_cur.sda_low  = ~rd[7];
      next_cur.shift    = {rd[6:0], 1'b0};
      if (cur.ptr[`AUTO_INC_BIT]) begin
        next_cur.ptr = {1'b1, cur.ptr[6:0] + 7'h01};
      end
    end

    // Register writes and their side effects
    if (wr_en) begin
      case (cur.ptr[6:0])
        `REG_MEASURE_CMD:    meas_req = (cur.shift != 8'h00);
        `REG_MAX_COUNT:      next_cur.max_count = cur.shift;
        `REG_ACQ_SETUP:      next_cur.acq_setup = cur.shift;
        `REG_UNLOCK_UPPER:   next_cur.unlock_hi = cur.shift;
        `REG_UNLOCK_LOWER:   next_cur.unlock_lo = cur.shift;
        `REG_ALT_ADDR: begin
          if ({cur.unlock_hi, cur.unlock_lo} == SERIAL_NUMBER) begin
            next_cur.alt_addr = cur.shift;
          end
        end
        `REG_LEVEL_OVERRIDE: next_cur.level_override = cur.shift;
        `REG_ADDR_CTRL:      next_cur.addr_ctrl = cur.shift;
        `REG_RX_SHUTDOWN:    next_cur.rx_shutdown = cur.shift;
        default: ;
      endcase
    end

    // Receiver power: off only while idle, settle time reloaded meanwhile
    next_cur.rx_off = cur.rx_shutdown[`RX_OFF_BIT] && (cur.mst == M_IDLE);
    if (cur.rx_off) begin
      next_cur.settle = 10'(`RX_SETTLE_CYCLES);
    end else if (cur.settle != 10'h000) begin
      next_cur.settle = cur.settle - 10'h001;
    end

    // Pin held low by the host, seen only when the device is not driving
    pin_req = ~cur.pin_s & ~cur.pin_drive;

    // Measurement sequencer
    case (cur.mst)
      M_BOOT: begin
        if (cur.boot_cnt == 22'(STARTUP_CYCLES - 1)) begin
          next_cur.mst = M_IDLE;
        end else begin
          next_cur.boot_cnt = cur.boot_cnt + 22'h000001;
        end
      end
      M_IDLE: begin
        if (meas_req) begin
          next_cur.from_pin = 1'b0;
          next_cur.mst      = M_WAKE;
        end else if (pin_req) begin
          next_cur.from_pin = 1'b1;
          next_cur.mst      = M_WAKE;
        end
      end
      M_WAKE: begin
        if (cur.settle == 10'h000) begin
          if (cur.since_cal == 3'h0) begin
            next_cur.mst       = M_CAL;
            next_cur.cal_start = 1'b1;
          end else begin
            next_cur.mst       = M_CLEAR;
            next_cur.clear_rec = 1'b1;
          end
        end
      end
      M_CAL: begin
        if (i_afe.cal_done) begin
          next_cur.since_cal = `CAL_PERIOD;
          next_cur.mst       = M_CLEAR;
          next_cur.clear_rec = 1'b1;
        end
      end
      M_CLEAR: begin
        next_cur.acq_cnt   = 9'h000;
        next_cur.acq_start = 1'b1;
        next_cur.mst       = M_ACQ;
      end
      M_ACQ: begin
        if (i_afe.acq_done) begin
          next_cur.acq_cnt = cnt_inc;
          if (i_afe.peak_saturated || (cnt_inc >= {1'b0, cur.max_count}) ||
              (!cur.acq_setup[`QUICK_TERM_OFF_BIT] && i_afe.peak_predict)) begin
            next_cur.mst = M_EVAL;
          end else begin
            next_cur.acq_start = 1'b1;
          end
        end
      end
      M_EVAL: begin
        next_cur.distance = peak_valid ? i_afe.target_cm : `INVALID_DISTANCE;
        if (cur.since_cal != 3'h0) begin
          next_cur.since_cal = cur.since_cal - 3'h1;
        end
        if (cur.from_pin && (next_cur.distance != 16'h0000)) begin
          next_cur.mst       = M_PULSE;
          next_cur.pin_drive = 1'b1;
          next_cur.cm_left   = next_cur.distance;
          next_cur.tick      = 10'h000;
        end else begin
          next_cur.mst = M_IDLE;
        end
      end
      M_PULSE: begin
        if (cur.tick == 10'(`CYC_PER_CM - 1)) begin
          next_cur.tick    = 10'h000;
          next_cur.cm_left = cur.cm_left - 16'h0001;
          if (cur.cm_left == 16'h0001) begin
            next_cur.pin_drive = 1'b0;
            next_cur.mst       = M_IDLE;
          end
        end else begin
          next_cur.tick = cur.tick + 10'h001;
        end
      end
      default: next_cur.mst = M_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register; alternate address clears on every reset
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cur <= RESET_STATE;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_sda_out  = 1'b0;
  assign o_sda_oe_n = ~cur.sda_low;
  assign o_pin_out  = 1'b1;
  assign o_pin_oe_n = ~cur.pin_drive;
  assign o_afe      = '{rx_power_down: cur.rx_off, cal_start: cur.cal_start,
                        record_clear: cur.clear_rec, acq_start: cur.acq_start};

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  AST_BOOT_QUIET: assert property (cur.mst == M_BOOT |-> !cur.cal_start && !cur.acq_start)
    else $error("Measurement activity during start-up");
  AST_DEFAULT_ACK: assert property (cur.bst == ST_ADDR && scl_fall && cur.bcnt == 4'h8 &&
      cur.shift[7:1] == 7'h62 && !cur.addr_ctrl[3] |=> cur.sda_low && cur.bst == ST_ACK_ADDR)
    else $error("Default address not acknowledged");
  AST_GENERAL_CALL: assert property (cur.bst == ST_ADDR && scl_fall && cur.bcnt == 4'h8 &&
      cur.shift[7:1] == 7'h00 |=> cur.bst == ST_IDLE && !cur.sda_low)
    else $error("General call was answered");
  AST_BUSY_STATUS: assert property ($rose(cur.acq_start) |-> busy && cur.mst == M_ACQ)
    else $error("Acquisition without busy status");
  AST_CLEAR_FIRST: assert property (cur.clear_rec |=> cur.acq_start ##1 cur.mst == M_ACQ)
    else $error("Acquisition did not follow record clear");
  AST_LIMIT_STOP: assert property (cur.mst == M_ACQ && i_afe.acq_done &&
      (cur.acq_cnt + 9'h001) >= {1'b0, cur.max_count} |=> cur.mst == M_EVAL)
    else $error("Acquisition count limit not honoured");
  AST_INVALID_1CM: assert property (cur.mst == M_EVAL && !peak_valid |=>
      cur.distance == 16'h0001)
    else $error("Invalid measurement not reported as 1 cm");
  AST_RX_OFF_IDLE: assert property (cur.rx_off |-> $past(cur.mst) == M_IDLE)
    else $error("Receiver off outside idle");
  AST_PULSE_END: assert property (cur.mst == M_PULSE && cur.cm_left == 16'h0001 &&
      cur.tick == 10'h3e7 |=> !cur.pin_drive && o_pin_oe_n)
    else $error("Pulse did not end after last centimetre");
  AST_NO_RESTART: assert property (busy && cur.mst != M_EVAL && cur.mst != M_PULSE |=>
      cur.mst != M_WAKE || $past(cur.mst) == M_WAKE)
    else $error("Measurement restarted while busy");

endmodule
`default_nettype wire

// file: laser_ranger_control_interface_tb.sv
// Bench of the ranger control block
`timescale 1ns/1ps
`default_nettype none
module laser_ranger_control_interface_tb;
  import ranger_pkg::*;
  localparam logic [15:0] SN = 16'h2b6e;  // Arbitrary value
  logic        clk, rst, scl, sda_rel, sda_out, sda_oe_n, pin_low, pin_out, pin_oe_n, ak;
  logic [7:0]  rb [4];
  logic [8:0]  r;
  int          err_count, comparisons, cycles, dly, n, a, acqs;
  afe_result_t afe;
  afe_ctrl_t   ctl;
  logic        fe_cal, fe_acq;
  // Pulled-up lines: open-drain data, pin pulled low by the host
  wire logic   sda = sda_rel & (sda_oe_n | sda_out);
  wire logic   pin = !pin_low | (!pin_oe_n & pin_out);

  laser_ranger_control_interface #(.STARTUP_CYCLES(50), .SERIAL_NUMBER(SN)) DUT (
    .i_core_clk(clk), .i_reset(rst), .i_scl_in(scl), .i_sda_in(sda), .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n), .i_pin_in(pin), .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n),
    .i_afe({fe_cal, fe_acq, afe[49:0]}), .o_afe(ctl));
  ranger_host_bus host (.i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel));

  // Clock of 10 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // Front end: calibration ends at once, each acquisition after 20 cycles
  always @(negedge clk) begin
    fe_cal <= ctl.cal_start;
    fe_acq <= (dly == 1);
    if (ctl.acq_start) acqs <= acqs + 1;
    dly <= ctl.acq_start ? 20 : (dly > 0 ? dly - 1 : 0);
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      results();
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Register write; ak is the address answer bit
  task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic k);
    host.frame(1'b1);
    host.xfer({a, 2'b01}, r);
    k = r[0];
    host.xfer({p, 1'b1}, r);
    host.xfer({d, 1'b1}, r);
    host.frame(1'b0);
  endtask
  // Pointer write, stop, then read cnt bytes with a refusal on the last
  task automatic rd(input logic [7:0] p, input int cnt);
    host.frame(1'b1);
    host.xfer({8'hc4, 1'b1}, r);
    host.xfer({p, 1'b1}, r);
    host.frame(1'b0);
    host.frame(1'b1);
    host.xfer({8'hc5, 1'b1}, r);
    for (int i = 0; i < cnt; i++) begin
      host.xfer({8'hff, i == cnt - 1}, r);
      rb[i] = r[8:1];
    end
    host.frame(1'b0);
  endtask
  // Command, poll busy, read the distance pair
  task automatic measure(input logic [15:0] exp, input logic chk_busy);
    wr(7'h62, 8'h00, 8'h04, ak);
    rd(8'h01, 1);
    if (chk_busy) check("busy", {15'h0, rb[0][0]}, 16'h1);
    for (int i = 0; i < 100 && rb[0][0] !== 1'b0; i++) rd(8'h01, 1);
    check("status", {8'h0, rb[0]}, 16'h0);
    rd(8'h8f, 2);
    check("distance", {rb[0], rb[1]}, exp);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    pin_low = 1'b0;
    afe = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd(8'h82, 3);
    check("max_count", {8'h0, rb[0]}, 16'h00ff);
    check("acq_setup", {8'h0, rb[2]}, 16'h0008);
    rd(8'h9c, 3);
    check("override", {8'h0, rb[0]}, 16'h0000);
    check("addr_ctrl", {8'h0, rb[2]}, 16'h0000);
    rd(8'h65, 1);
    check("shutdown", {8'h0, rb[0]}, 16'h0000);
    $display("reset done");
    afe.peak = 16'h0064;
    afe.noise_floor = 16'h000a;
    afe.target_cm = 16'h012c;
    measure(16'h012c, 1'b1);
    wr(7'h62, 8'h1c, 8'h60, ak);
    afe.peak = 16'h0050;
    measure(16'h0001, 1'b1);
    wr(7'h62, 8'h1c, 8'h00, ak);
    afe.peak = 16'h0064;
    wr(7'h62, 8'h65, 8'h02, ak);
    check("rx_off", {15'h0, ctl.rx_power_down}, 16'h1);
    wr(7'h62, 8'h65, 8'h00, ak);
    check("rx_on", {15'h0, ctl.rx_power_down}, 16'h0);
    wr(7'h62, 8'h02, 8'h03, ak);
    a = acqs;
    measure(16'h012c, 1'b0);
    check("acq_limit", 16'(acqs - a), 16'h0003);
    wr(7'h62, 8'h04, 8'h00, ak);
    afe.peak_predict = 1'b1;
    a = acqs;
    measure(16'h012c, 1'b0);
    check("quick_term", 16'(acqs - a), 16'h0001);
    afe.peak_predict = 1'b0;
    afe.peak_saturated = 1'b1;
    afe.noise_floor = 16'h0050;
    a = acqs;
    measure(16'h0001, 1'b0);
    check("saturated", 16'(acqs - a), 16'h0001);
    afe.peak_saturated = 1'b0;
    afe.noise_floor = 16'h000a;
    $display("measure done");
    wr(7'h63, 8'h1c, 8'h00, ak);
    check("other_ack", {15'h0, ak}, 16'h1);
    wr(7'h00, 8'h1c, 8'h00, ak);
    check("gcall_ack", {15'h0, ak}, 16'h1);
    afe.target_cm = 16'h0002;
    pin_low = 1'b1;
    repeat (10) @(negedge clk);
    pin_low = 1'b0;
    for (n = 0; n < 20000 && pin_oe_n !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 5000 && pin_oe_n === 1'b0; n++) @(negedge clk);
    check("pulse", n[15:0], 16'h07d0);
    pin_low = 1'b1;
    for (n = 0; n < 5000 && pin_oe_n !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 5000 && pin_oe_n === 1'b0; n++) @(negedge clk);
    for (n = 0; n < 5000 && pin_oe_n !== 1'b0; n++) @(negedge clk);
    check("pulse_train", {15'h0, pin_oe_n}, 16'h0);
    pin_low = 1'b0;
    for (n = 0; n < 5000 && pin_oe_n === 1'b0; n++) @(negedge clk);
    $display("pin done");
    rd(8'h96, 2);
    check("serial", {rb[0], rb[1]}, SN);
    wr(7'h62, 8'h1a, 8'h44, ak);
    wr(7'h44, 8'h1c, 8'h00, ak);
    check("locked", {15'h0, ak}, 16'h1);
    wr(7'h62, 8'h18, rb[0], ak);
    wr(7'h62, 8'h19, rb[1], ak);
    wr(7'h62, 8'h1a, 8'h44, ak);
    wr(7'h62, 8'h1e, 8'h08, ak);
    wr(7'h44, 8'h1c, 8'h00, ak);
    check("alt_ack", {15'h0, ak}, 16'h0);
    wr(7'h62, 8'h1c, 8'h00, ak);
    check("dflt_off", {15'h0, ak}, 16'h1);
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    wr(7'h62, 8'h1c, 8'h00, ak);
    check("dflt_back", {15'h0, ak}, 16'h0);
    $display("address done");
    results();
  end
endmodule
`default_nettype wire

// file: ranger_host_bus.sv
// Host bus master model that clocks frames and bytes over the two-wire port
`timescale 1ns/1ps
`default_nettype none
module ranger_host_bus (
  // Clock and bus wires
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_rel
);
  // Bus idles released with the clock high
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
  end
  // Quarter of a 160 ns bus clock
  task automatic q();
    repeat (4) @(negedge i_core_clk);
  endtask
  // Start (st=1) or stop: data is first set to st, then flips to !st while the clock is high
  task automatic frame(input logic st);
    o_sda_rel = st;
    q();
    o_scl = 1'b1;
    q();
    o_sda_rel = !st;
    q();
    o_scl = !st;
  endtask
  // Eight bits and the answer bit; data changes only while the clock is low
  task automatic xfer(input logic [8:0] d, output logic [8:0] rv);
    for (int i = 8; i >= 0; i--) begin
      o_sda_rel = d[i];
      q();
      o_scl = 1'b1;
      q();
      rv[i] = i_sda;
      q();
      o_scl = 1'b0;
      q();
    end
  endtask
endmodule
`default_nettype wire

// file: ranger_params.svh
// Offsets, reset values, field positions and timing counts of the ranger control block
`ifndef RANGER_PARAMS_SVH
`define RANGER_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (seven-bit pointer space)
// ----------------------------------------------------------------------
`define REG_MEASURE_CMD      7'h00
`define REG_STATUS           7'h01
`define REG_MAX_COUNT        7'h02
`define REG_ACQ_SETUP        7'h04
`define REG_DIST_HIGH        7'h0f
`define REG_DIST_LOW         7'h10
`define REG_SERIAL_UPPER     7'h16
`define REG_SERIAL_LOWER     7'h17
`define REG_UNLOCK_UPPER     7'h18
`define REG_UNLOCK_LOWER     7'h19
`define REG_ALT_ADDR         7'h1a
`define REG_LEVEL_OVERRIDE   7'h1c
`define REG_ADDR_CTRL        7'h1e
`define REG_RX_SHUTDOWN      7'h65

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define RST_MAX_COUNT        8'hff
`define RST_ACQ_SETUP        8'h08
`define RST_LEVEL_OVERRIDE   8'h00
`define RST_ADDR_CTRL        8'h00
`define RST_RX_SHUTDOWN      8'h00
`define DEFAULT_BUS_ADDR     7'h62
`define QUICK_TERM_OFF_BIT   3
`define DEFAULT_ADDR_OFF_BIT 3
`define RX_OFF_BIT           1
`define STATUS_BUSY_BIT      0
`define AUTO_INC_BIT         7
`define INVALID_DISTANCE     16'h0001
`define CAL_PERIOD           3'h4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ              100
`define STARTUP_MS           22
`define STARTUP_CYCLES       (`STARTUP_MS * 1000 * `CLK_MHZ)
`define PULSE_US_PER_CM      10
`define CYC_PER_CM           (`PULSE_US_PER_CM * `CLK_MHZ)
`define RX_SETTLE_US         5
`define RX_SETTLE_CYCLES     (`RX_SETTLE_US * `CLK_MHZ)

`endif

// file: ranger_pkg.sv
// Types shared by the ranger control block
package ranger_pkg;

  // Serial slave bus states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WDATA, ST_ACK_W, ST_RDATA, ST_ACK_R
  } bus_state_t;

  // Measurement sequencer states
  typedef enum logic [2:0] {
    M_BOOT, M_IDLE, M_WAKE, M_CAL, M_CLEAR, M_ACQ, M_EVAL, M_PULSE
  } meas_state_t;

  // Results from the analog front end, same clock
  typedef struct packed {
    logic        cal_done;
    logic        acq_done;
    logic        peak_saturated;
    logic        peak_predict;
    logic [15:0] peak;
    logic [15:0] noise_floor;
    logic [15:0] target_cm;
  } afe_result_t;

  // Controls towards the analog front end
  typedef struct packed {
    logic rx_power_down;
    logic cal_start;
    logic record_clear;
    logic acq_start;
  } afe_ctrl_t;

  // Whole state of the control block
  typedef struct packed {
    logic        scl_m;
    logic        scl_s;
    logic        scl_d;
    logic        sda_m;
    logic        sda_s;
    logic        sda_d;
    logic        pin_m;
    logic        pin_s;
    bus_state_t  bst;
    logic [3:0]  bcnt;
    logic [7:0]  shift;
    logic        rw;
    logic        first;
    logic        nack;
    logic        sda_low;
    logic [7:0]  ptr;
    logic [7:0]  max_count;
    logic [7:0]  acq_setup;
    logic [7:0]  level_override;
    logic [7:0]  addr_ctrl;
    logic [7:0]  alt_addr;
    logic [7:0]  unlock_hi;
    logic [7:0]  unlock_lo;
    logic [7:0]  rx_shutdown;
    meas_state_t mst;
    logic [21:0] boot_cnt;
    logic [9:0]  settle;
    logic [8:0]  acq_cnt;
    logic [2:0]  since_cal;
    logic        from_pin;
    logic [15:0] distance;
    logic [15:0] cm_left;
    logic [9:0]  tick;
    logic        pin_drive;
    logic        rx_off;
    logic        cal_start;
    logic        clear_rec;
    logic        acq_start;
  } core_state_t;

endpackage
